// ### include/bsc_tx_pkg.sv
// constants, character codes and state types for the synchronous transmit framer
package bsc_tx_pkg;

  // link control characters (ascii set)
  localparam logic [7:0] SYN_CHAR = 8'h16;
  localparam logic [7:0] SOH_CHAR = 8'h01;
  localparam logic [7:0] STX_CHAR = 8'h02;
  localparam logic [7:0] ETX_CHAR = 8'h03;
  localparam logic [7:0] EOT_CHAR = 8'h04;
  localparam logic [7:0] ENQ_CHAR = 8'h05;
  localparam logic [7:0] DLE_CHAR = 8'h10;
  localparam logic [7:0] NAK_CHAR = 8'h15;
  localparam logic [7:0] ETB_CHAR = 8'h17;
  localparam logic [7:0] ITB_CHAR = 8'h1f;
  localparam logic [7:0] PAD_CHAR = 8'hff;

  // read-back select codes
  localparam logic [1:0] SEL_DATA   = 2'h0;
  localparam logic [1:0] SEL_STATUS = 2'h1;

  // line-status byte bit positions
  localparam int ST_UNDERFLOW = 7;
  localparam int ST_STATUS_IN = 6;
  localparam int ST_RING      = 5;
  localparam int ST_CTRL_DET  = 4;
  localparam int ST_OUT_DONE  = 3;
  localparam int ST_CTS       = 2;
  localparam int ST_CARRIER   = 1;
  localparam int ST_INTERLOCK = 0;

  // block check: reflected crc-16, sent low byte first
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_INIT = 16'h0000;

  // serial character framing
  localparam logic [2:0] BIT_LAST   = 3'h7;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // one-second fill interval at the system clock rate
  localparam int FILL_TIME_MS      = 1000;
  localparam int SYS_CLK_PERIOD_NS = 40;
  localparam int FILL_CYCLE_COUNT  = FILL_TIME_MS * 1000000 / SYS_CLK_PERIOD_NS;

  typedef enum {S_IDLE, S_LEAD, S_DATA, S_PEND, S_BCC1, S_BCC2, S_PAD, S_FIN, S_HOLD} txState_t;
  typedef enum {NX_DATA, NX_BCC, NX_PAD} pendNext_t;

endpackage

// ### hdl/bsc_transmit_framer.sv
// transmit framer: host byte port, fill timer, status read-back and serial link side
`timescale 1ns/1ps
module bsc_transmit_framer
  import bsc_tx_pkg::*;
#(
  parameter int FILL_CYCLES = bsc_tx_pkg::FILL_CYCLE_COUNT
) (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       txStart,
  input  wire logic       txStop,
  input  wire logic       noBlockCheck,
  input  wire logic       testMode,
  input  wire logic       parityEnable,
  input  wire logic [7:0] inByte,
  input  wire logic       inCountZero,
  input  wire logic       inValid,
  output logic            inReady,
  input  wire logic [1:0] readSelect,
  output logic [7:0]      readData,
  output logic            transmitBit,
  output logic            outputDone,
  output logic            underflow,
  output logic            statusChange,
  input  wire logic       lineClk,
  input  wire logic       clearToSend,
  input  wire logic       carrierOn,
  input  wire logic       interlock,
  input  wire logic       ringIndicator,
  input  wire logic       statusLineIn,
  output logic            requestToSend,
  output logic            txData
);
  import bsc_tx_pkg::*;

  // the fill counter is 25 bits wide, so longer intervals cannot be served
  initial if (FILL_CYCLES < 2 || FILL_CYCLES > 33554431) $error("FILL_CYCLES out of range");

  function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // system clock domain
  logic [7:0]  hostByteQ;
  logic        hostZeroQ, loadTogQ, transmitQ, ocQ, underQ, fillReqTogQ;
  logic [24:0] fillCntQ;
  logic [4:0]  modemMetaQ, modemSyncQ;
  logic [3:0]  evMetaQ, evSyncQ, evPrevQ;   // ack, done, under, clear
  logic        fillAckMetaQ, fillAckSyncQ, fillAckPrevQ;
  logic        doneEdge, underEdge, clearEdge, ackEdgeless, fillAckEdge;
  logic [7:0]  statusByte;

  // line-domain registers read across
  logic        seenTogQ, doneTogQ, underTogQ, clearTogQ, fillTogQ;

  // events and acknowledges from the link side: two flops then edge detect
  always_ff @(posedge sys_clk) begin
    evMetaQ      <= {seenTogQ, doneTogQ, underTogQ, clearTogQ};
    evSyncQ      <= evMetaQ;
    evPrevQ      <= evSyncQ;
    fillAckMetaQ <= fillTogQ;
    fillAckSyncQ <= fillAckMetaQ;
    fillAckPrevQ <= fillAckSyncQ;
    modemMetaQ   <= {statusLineIn, ringIndicator, clearToSend, carrierOn, interlock};
    modemSyncQ   <= modemMetaQ;
  end
  assign doneEdge    = evSyncQ[2] ^ evPrevQ[2];
  assign underEdge   = evSyncQ[1] ^ evPrevQ[1];
  assign clearEdge   = evSyncQ[0] ^ evPrevQ[0];
  assign fillAckEdge = fillAckSyncQ ^ fillAckPrevQ;
  assign ackEdgeless = (evSyncQ[3] == loadTogQ);
  // one byte slot; refill only once the link side has taken the last byte
  assign inReady = ackEdgeless;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      hostByteQ <= RESET_BYTE;
      hostZeroQ <= 1'b0;
      loadTogQ  <= 1'b0;
    end else if (inValid && inReady) begin
      hostByteQ <= inByte;
      hostZeroQ <= inCountZero;
      loadTogQ  <= ~loadTogQ;
    end
  end

  // transmit bit: software sets, software or the framer clears; set wins
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      transmitQ <= 1'b0;
    end else if (txStart) begin
      transmitQ <= 1'b1;
    end else if (txStop || clearEdge) begin
      transmitQ <= 1'b0;
    end
  end

  // sticky status bits, cleared at a new start unless set in the same cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ocQ    <= 1'b0;
      underQ <= 1'b0;
    end else begin
      ocQ    <= doneEdge || underEdge || (ocQ && !txStart);
      underQ <= underEdge || (underQ && !txStart);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || !transmitQ || fillAckEdge) begin
      fillCntQ <= '0;
    end else if (fillCntQ != 25'(FILL_CYCLES - 1)) begin
      fillCntQ <= fillCntQ + 25'h0000001;
    end
  end

  // request a fill once per interval; only one request outstanding
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fillReqTogQ <= 1'b0;
    end else if (fillCntQ == 25'(FILL_CYCLES - 1) && fillAckSyncQ == fillReqTogQ && !fillAckEdge) begin
      fillReqTogQ <= ~fillReqTogQ;
    end
  end

  always_comb begin
    statusByte               = 8'h00;
    statusByte[ST_UNDERFLOW] = underQ;
    statusByte[ST_STATUS_IN] = modemSyncQ[4];
    statusByte[ST_RING]      = modemSyncQ[3];
    statusByte[ST_CTRL_DET]  = 1'b0;
    statusByte[ST_OUT_DONE]  = ocQ;
    statusByte[ST_CTS]       = modemSyncQ[2];
    statusByte[ST_CARRIER]   = modemSyncQ[1];
    statusByte[ST_INTERLOCK] = modemSyncQ[0];
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      readData <= RESET_BYTE;
    end else if (readSelect == SEL_DATA) begin
      readData <= hostByteQ;
    end else if (readSelect == SEL_STATUS) begin
      readData <= statusByte;
    end else begin
      readData <= 8'h00;
    end
  end

  // event pulses, registered
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      outputDone   <= 1'b0;
      underflow    <= 1'b0;
      statusChange <= 1'b0;
    end else begin
      outputDone   <= doneEdge || underEdge;
      underflow    <= underEdge;
      statusChange <= doneEdge || underEdge;
    end
  end
  assign transmitBit   = transmitQ;
  assign requestToSend = transmitQ;

  // link clock domain
  logic       rstMetaQ, lineResetQ;
  logic [6:0] cfgMetaQ, cfgSyncQ;   // txEn, cts, load, fillReq, nbc, test, parity
  txState_t   stateQ, stateD;
  pendNext_t  nextQ, nextD;
  logic [2:0] bitCntQ;
  logic [7:0] shiftQ, byteD, pendQ, pendD, lastByteQ;
  logic [15:0] crcQ;
  logic       pendCrcQ, pendCrcD, transQ, transD, inTextQ, inTextD, bccOnQ, bccOnD;
  logic       dleSeenQ, dleSeenD, itbQ, itbD, underSeenQ;
  logic       take, crcIn, crcClr, doneEv, clearEv, underEv, fillEv, boundary;
  logic       txEn, cts, avail, fillPend, nbc, tst, par;
  logic [7:0] b;

  // reset and quasi-static controls enter the link domain through two flops
  always_ff @(posedge lineClk) begin
    rstMetaQ   <= reset;
    lineResetQ <= rstMetaQ;
    cfgMetaQ   <= {transmitQ, clearToSend, loadTogQ, fillReqTogQ, noBlockCheck, testMode, parityEnable};
    cfgSyncQ   <= cfgMetaQ;
  end
  assign txEn     = cfgSyncQ[6];
  assign cts      = cfgSyncQ[5];
  assign avail    = cfgSyncQ[4] != seenTogQ;
  assign fillPend = cfgSyncQ[3] != fillTogQ;
  assign nbc      = cfgSyncQ[2];
  assign tst      = cfgSyncQ[1];
  assign par      = cfgSyncQ[0];
  assign boundary = (bitCntQ == BIT_LAST);
  // held stable by the slot handshake while the toggles differ
  assign b = hostByteQ;

  // framing decision taken once per character time
  always_comb begin
    stateD = stateQ;  nextD = nextQ;  pendD = pendQ;  pendCrcD = pendCrcQ;
    transD = transQ;  inTextD = inTextQ;  bccOnD = bccOnQ;  dleSeenD = dleSeenQ;  itbD = itbQ;
    byteD = PAD_CHAR; take = 1'b0; crcIn = 1'b0; crcClr = 1'b0;
    doneEv = 1'b0; clearEv = 1'b0; underEv = 1'b0; fillEv = 1'b0;
    case (stateQ)
      S_IDLE: begin
        if (txEn && cts) begin
          byteD = SYN_CHAR;  stateD = S_LEAD;  crcClr = 1'b1;
          transD = 1'b0;  inTextD = 1'b0;  bccOnD = 1'b0;  dleSeenD = 1'b0;  itbD = 1'b0;
        end
      end
      S_LEAD: begin
        byteD = SYN_CHAR;
        stateD = S_DATA;
      end
      S_DATA: begin
        if (!txEn) begin
          stateD = S_IDLE;
        end else if (fillPend && inTextQ && !tst) begin
          fillEv = 1'b1;  byteD = transQ ? DLE_CHAR : SYN_CHAR;
          pendD = SYN_CHAR;  pendCrcD = 1'b0;  nextD = NX_DATA;  stateD = S_PEND;
        end else if (avail) begin
          take = 1'b1;
          byteD = (par && !transQ) ? {~^b[6:0], b[6:0]} : b;
          if (tst) begin
            byteD = par ? {~^b[6:0], b[6:0]} : b;
          end else if (transQ) begin
            if (b == DLE_CHAR) begin
              crcIn = 1'b1;  pendD = DLE_CHAR;  pendCrcD = 1'b0;  nextD = NX_DATA;  stateD = S_PEND;
            end else if (hostZeroQ && (b == ETB_CHAR || b == ETX_CHAR || (b == ITB_CHAR && !nbc))) begin
              byteD = DLE_CHAR;  pendD = b;  pendCrcD = 1'b1;  nextD = NX_BCC;  stateD = S_PEND;
              itbD = (b == ITB_CHAR);
            end else if (hostZeroQ && (b == ENQ_CHAR || b == EOT_CHAR)) begin
              byteD = DLE_CHAR;  pendD = b;  pendCrcD = 1'b0;  nextD = NX_PAD;  stateD = S_PEND;
            end else begin
              crcIn = 1'b1;
            end
          end else if (dleSeenQ) begin
            dleSeenD = 1'b0;
            if (b == STX_CHAR) begin
              transD = 1'b1;  inTextD = 1'b1;  bccOnD = 1'b1;
              crcClr = !bccOnQ;  crcIn = bccOnQ;
            // escape sequence outside text ends like enquiry
            end else if (!inTextQ) begin
              stateD = S_PAD;
            end else begin
              crcIn = bccOnQ;
            end
          end else if (b == SYN_CHAR) begin
            crcIn = 1'b0;
          end else if (b == DLE_CHAR) begin
            dleSeenD = 1'b1;  crcIn = bccOnQ;
          end else if (b == SOH_CHAR || b == STX_CHAR) begin
            inTextD = 1'b1;  bccOnD = 1'b1;  crcClr = !bccOnQ;  crcIn = bccOnQ;
          end else if (inTextQ && (b == ETB_CHAR || b == ETX_CHAR || (b == ITB_CHAR && !nbc))) begin
            crcIn = 1'b1;  stateD = S_BCC1;  itbD = (b == ITB_CHAR);
          end else if (b == EOT_CHAR || b == ENQ_CHAR || (b == NAK_CHAR && !inTextQ)) begin
            stateD = S_PAD;
          end else begin
            crcIn = bccOnQ;
          end
        end else begin
          // starved: keep character sync with idle fill
          byteD = SYN_CHAR;
          if (transQ && !tst) begin
            byteD = DLE_CHAR;  pendD = SYN_CHAR;  pendCrcD = 1'b0;  nextD = NX_DATA;  stateD = S_PEND;
          end
          // underflow only in test mode, once until the next byte is taken
          underEv = tst && !underSeenQ;
        end
      end
      S_PEND: begin
        byteD = pendQ;  crcIn = pendCrcQ;
        stateD = (nextQ == NX_BCC) ? S_BCC1 : (nextQ == NX_PAD) ? S_PAD : S_DATA;
      end
      S_BCC1: begin
        byteD = crcQ[7:0];
        stateD = S_BCC2;
      end
      S_BCC2: begin
        byteD = crcQ[15:8];
        // intermediate end: report, stay and fetch next block
        if (itbQ) begin
          doneEv = 1'b1;  crcClr = 1'b1;  inTextD = 1'b0;  transD = 1'b0;  itbD = 1'b0;
          stateD = S_DATA;
        end else begin
          stateD = S_PAD;
        end
      end
      S_PAD: begin
        byteD = PAD_CHAR;
        stateD = S_FIN;
      end
      S_FIN: begin
        // done and clear once the pad has left
        doneEv = 1'b1;  clearEv = 1'b1;  transD = 1'b0;  inTextD = 1'b0;  bccOnD = 1'b0;
        stateD = S_HOLD;
      end
      S_HOLD: begin
        if (!txEn) begin
          stateD = S_IDLE;
        end
      end
      default: stateD = S_IDLE;
    endcase
  end

  // bit shifter, lsb first, characters back to back; the ones shifted in behind each character are never sent
  always_ff @(posedge lineClk) begin
    if (lineResetQ) begin
      bitCntQ   <= 3'h0;
      shiftQ    <= PAD_CHAR;
      lastByteQ <= PAD_CHAR;
    end else begin
      bitCntQ <= bitCntQ + 3'h1;
      if (boundary) begin
        shiftQ    <= byteD;
        lastByteQ <= byteD;
      end else begin
        shiftQ <= {1'b1, shiftQ[7:1]};
      end
    end
  end
  assign txData = shiftQ[0];

  // framer state, updated only at character boundaries
  always_ff @(posedge lineClk) begin
    if (lineResetQ) begin
      stateQ <= S_IDLE;  nextQ <= NX_DATA;  pendQ <= RESET_BYTE;  pendCrcQ <= 1'b0;
      transQ <= 1'b0;  inTextQ <= 1'b0;  bccOnQ <= 1'b0;  dleSeenQ <= 1'b0;  itbQ <= 1'b0;
    end else if (boundary) begin
      stateQ <= stateD;  nextQ <= nextD;  pendQ <= pendD;  pendCrcQ <= pendCrcD;
      transQ <= transD;  inTextQ <= inTextD;  bccOnQ <= bccOnD;  dleSeenQ <= dleSeenD;  itbQ <= itbD;
    end
  end

  // block check accumulation over the bytes actually sent
  always_ff @(posedge lineClk) begin
    if (lineResetQ) begin
      crcQ <= CRC_INIT;
    end else if (boundary && crcClr) begin
      crcQ <= CRC_INIT;
    end else if (boundary && crcIn) begin
      crcQ <= crcByte(crcQ, byteD);
    end
  end

  // handshake and event toggles toward the system domain
  always_ff @(posedge lineClk) begin
    if (lineResetQ) begin
      seenTogQ <= 1'b0;  doneTogQ <= 1'b0;  underTogQ <= 1'b0;  clearTogQ <= 1'b0;
      fillTogQ <= 1'b0;  underSeenQ <= 1'b0;
    end else if (boundary) begin
      if (take) seenTogQ <= cfgSyncQ[4];
      if (fillEv) fillTogQ <= cfgSyncQ[3];
      if (doneEv) doneTogQ <= ~doneTogQ;
      if (clearEv) clearTogQ <= ~clearTogQ;
      if (underEv) underTogQ <= ~underTogQ;
      underSeenQ <= underEv || (underSeenQ && !take);
    end
  end

  // checks
  lead_sync_a: assert property (@(posedge lineClk) disable iff (lineResetQ)
    (boundary && stateQ == S_LEAD) |=> (lastByteQ == SYN_CHAR && $past(lastByteQ, 8) == SYN_CHAR))
    else $error("leading sync pair not sent");
  sync_unchecked_a: assert property (@(posedge lineClk) disable iff (lineResetQ)
    (boundary && take && !tst && !transQ && !dleSeenQ && b == SYN_CHAR) |=> $stable(crcQ))
    else $error("software sync entered the check");
  escape_double_a: assert property (@(posedge lineClk) disable iff (lineResetQ)
    (boundary && take && !tst && transQ && b == DLE_CHAR) |=> ##7 (stateQ == S_PEND && pendQ == DLE_CHAR && !pendCrcQ))
    else $error("transparent escape not doubled");
  trans_term_a: assert property (@(posedge lineClk) disable iff (lineResetQ)
    (boundary && take && !tst && transQ && hostZeroQ && b == ETX_CHAR) |=> (lastByteQ == DLE_CHAR) ##8 (lastByteQ == ETX_CHAR))
    else $error("transparent end lacks inserted escape");
  trans_fill_a: assert property (@(posedge lineClk) disable iff (lineResetQ)
    (boundary && fillEv && transQ) |=> (lastByteQ == DLE_CHAR) ##8 (lastByteQ == SYN_CHAR && $stable(crcQ)))
    else $error("transparent fill wrong");
  pad_done_a: assert property (@(posedge lineClk) disable iff (lineResetQ)
    (boundary && stateQ == S_PAD) |=> ##7 (boundary && doneEv && clearEv && lastByteQ == PAD_CHAR))
    else $error("done not raised after pad");
  under_done_a: assert property (@(posedge sys_clk) disable iff (reset)
    underflow |-> (outputDone && statusChange && ocQ && underQ))
    else $error("underflow without output done");
  read_status_a: assert property (@(posedge sys_clk) disable iff (reset)
    (readSelect == SEL_STATUS) |=> (readData == $past(statusByte)))
    else $error("status byte not returned");
  fill_restart_a: assert property (@(posedge sys_clk) disable iff (reset)
    (fillAckEdge && transmitQ) |=> (fillCntQ == 25'h0000000))
    else $error("fill timer not restarted");
  fill_pair_a: assert property (@(posedge lineClk) disable iff (lineResetQ)
    (boundary && fillEv && !transQ) |=> (lastByteQ == SYN_CHAR) ##8 (lastByteQ == SYN_CHAR && $stable(crcQ)))
    else $error("text fill pair wrong");

endmodule // bsc_transmit_framer

// ### sim/sync_modem.sv
// behavioural synchronous modem: line clock, clear-to-send and a character receiver
`timescale 1ns/1ps
module sync_modem
  import bsc_tx_pkg::*;
(
  input  wire logic requestToSend,
  input  wire logic txData,
  output logic      lineClk,
  output logic      clearToSend
);
  int         ctsDelay = 2;     // bench picks a prompt or a slow answer
  int         ctsCnt   = 0;
  logic [7:0] shiftR   = 8'hff;
  logic [2:0] bitCnt   = 3'h0;
  bit         locked   = 0;
  logic [7:0] got[$];

  // modem clock runs free, phase unrelated to the system clock
  initial begin
    lineClk = 1'b0;
    #1.7;
    forever #3 lineClk = ~lineClk;
  end

  // clear-to-send follows request-to-send after the chosen delay
  always @(posedge lineClk) begin
    if (requestToSend !== 1'b1) begin
      ctsCnt = 0;
      clearToSend <= 1'b0;
    end else if (ctsCnt < ctsDelay) begin
      ctsCnt++;
    end else begin
      clearToSend <= 1'b1;
    end
  end

  // sample mid-bit; hunt a sync byte once, then frame every eight bits (lsb first)
  always @(negedge lineClk) begin
    shiftR = {txData, shiftR[7:1]};
    bitCnt = bitCnt + 3'h1;
    if (!locked && shiftR == SYN_CHAR) begin
      locked = 1;
      bitCnt = 3'h0;
      got.push_back(shiftR);
    end else if (locked && bitCnt == 3'h0) begin
      got.push_back(shiftR);
    end
  end
endmodule // sync_modem

// ### sim/tb_top.sv
// self-checking bench for the transmit framer against a behavioural modem
`timescale 1ns/1ps
module tb_top;
  import bsc_tx_pkg::*;
  typedef logic [7:0] byteQ_t[$];
  logic        sys_clk = 0, reset = 1, txStart = 0, noBlockCheck = 0, inValid = 0, inCountZero = 0;
  logic        txStop = 0, testMode = 0, parityEnable = 0;
  logic        carrierOn = 0, interlock = 0, ringIndicator = 0, statusLineIn = 0;
  logic [7:0]  inByte = 8'h00, lastIn = 8'h00, ev;
  logic [1:0]  readSelect = 2'h0;
  logic [15:0] crc;
  wire logic   inReady, transmitBit, outputDone, underflow, statusChange;
  wire logic   lineClk, clearToSend, requestToSend, txData;
  wire logic [7:0] readData;
  int          error_cnt = 0, n_tests = 0, doneCnt = 0;
  byteQ_t      inQ, expQ;
  bit          zq[$];

  bsc_transmit_framer #(.FILL_CYCLES(30)) dut (.sys_clk(sys_clk), .reset(reset), .txStart(txStart),
    .txStop(txStop), .noBlockCheck(noBlockCheck), .testMode(testMode), .parityEnable(parityEnable), .inByte(inByte),
    .inCountZero(inCountZero), .inValid(inValid), .inReady(inReady), .readSelect(readSelect),
    .readData(readData), .transmitBit(transmitBit), .outputDone(outputDone), .underflow(underflow),
    .statusChange(statusChange), .lineClk(lineClk), .clearToSend(clearToSend), .carrierOn(carrierOn),
    .interlock(interlock), .ringIndicator(ringIndicator), .statusLineIn(statusLineIn),
    .requestToSend(requestToSend), .txData(txData));
  sync_modem model (.requestToSend(requestToSend), .txData(txData), .lineClk(lineClk),
    .clearToSend(clearToSend));

  // 25 MHz system clock
  always #20 sys_clk = ~sys_clk;

  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // printable bytes only, so no control character sneaks into data
  function automatic logic [7:0] rndChar();
    return 8'h20 + 8'($urandom % 95);
  endfunction

  // drop idle before the message and sync fill; escape+sync only once the opening escape+text start is out,
  // since a plain idle sync may sit between that escape and its text start
  function automatic byteQ_t filt(input byteQ_t s, input bit tr);
    byteQ_t f;
    bit     t;
    t = 1'b0;
    foreach (s[i]) begin
      if (s[i] == SYN_CHAR) begin
        if (t && f[$] == DLE_CHAR) void'(f.pop_back());
      end else if (f.size() > 0 || s[i] != PAD_CHAR) begin
        f.push_back(s[i]);
        t = t || (tr && f.size() == 2 && s[i] == STX_CHAR);
      end
    end
    return f;
  endfunction

  task automatic summarize();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk1(input string what, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic timeout(input string what);
    error_cnt++;
    $display("wrong value %s expected event seen timeout", what);
    summarize();
  endtask

  // queue one host byte; e: expected on the wire, a: part of the block check
  task automatic pin(input logic [7:0] b, input bit z, input bit e, input bit a);
    inQ.push_back(b);
    zq.push_back(z);
    if (e) expQ.push_back(b);
    if (a) crc = crcStep(crc, b);
  endtask

  task automatic pbcc();
    expQ.push_back(crc[7:0]);
    expQ.push_back(crc[15:8]);
    crc = CRC_INIT;
  endtask

  // software leading syncs, kept out of the check
  task automatic syncs();
    pin(SYN_CHAR, 0, 0, 0);
    pin(SYN_CHAR, 0, 0, 0);
  endtask

  task automatic msgStart();
    model.got.delete();
    crc = CRC_INIT;
    syncs();
    txStart = 1'b1;
    @(negedge sys_clk);
    txStart = 1'b0;
  endtask

  // valid stays up between bytes, so it is never assigned twice in a step
  task automatic feed();
    int k;
    while (inQ.size() > 0) begin
      inByte = inQ[0];
      inCountZero = zq[0];
      inValid = 1'b1;
      k = 0;
      while (inReady !== 1'b1) begin
        @(negedge sys_clk);
        k++;
        if (k > 3000) timeout("inReady");
      end
      @(negedge sys_clk);
      lastIn = inQ.pop_front();
      void'(zq.pop_front());
    end
    inValid = 1'b0;
  endtask

  task automatic waitDone(input logic expTb);
    int k;
    int tgt;
    tgt = doneCnt + 1;
    k = 0;
    while (doneCnt < tgt) begin
      @(negedge sys_clk);
      k++;
      if (k > 5000) timeout("outputDone");
    end
    repeat (20) @(negedge sys_clk);
    chk1("transmitBit", expTb, transmitBit);
  endtask

  task automatic cmpWire(input bit tr);
    byteQ_t g;
    byteQ_t e;
    g = filt(model.got, tr);
    e = filt(expQ, tr);
    foreach (e[i]) chk8("wire byte", e[i], i < g.size() ? g[i] : 8'hxx);
    expQ.delete();
  endtask

  // completion pulses; status change must travel with output done
  always @(posedge sys_clk) begin
    if (outputDone === 1'b1) doneCnt++;
    if (outputDone === 1'b1 || statusChange === 1'b1) chk1("statusChange", outputDone, statusChange);
    if (underflow === 1'b1) chk1("outputDone", 1'b1, outputDone);
  end

  initial begin
    void'($urandom(32'hf192b620));
    repeat (15) @(negedge sys_clk);
    chk1("inReady", 1'b1, inReady);
    chk1("txData", 1'b1, txData);
    @(negedge sys_clk);
    reset = 1'b0;
    repeat (10) @(negedge sys_clk);
    // plain text, slow clear-to-send
    model.ctsDelay = 40;
    msgStart();
    pin(STX_CHAR, 0, 1, 0);
    repeat (6) pin(rndChar(), 0, 1, 1);
    pin(ETX_CHAR, 1, 1, 1);
    pbcc();
    expQ.push_back(PAD_CHAR);
    feed();
    waitDone(1'b0);
    cmpWire(0);
    // read-back select codes with random modem levels
    for (int i = 0; i < 8; i++) begin
      {carrierOn, interlock, ringIndicator, statusLineIn} = 4'($urandom);
      readSelect = 2'(i);
      repeat (5) @(negedge sys_clk);
      ev = (i % 4 == 0) ? lastIn : (i % 4 == 1) ?
        {1'b0, statusLineIn, ringIndicator, 1'b0, 1'b1, clearToSend, carrierOn, interlock} : 8'h00;
      chk8("readData", ev, readData);
    end
    // an intermediate block then a final block, prompt clear-to-send
    model.ctsDelay = 2;
    msgStart();
    pin(STX_CHAR, 0, 1, 0);
    repeat (4) pin(rndChar(), 0, 1, 1);
    pin(ITB_CHAR, 1, 1, 1);
    pbcc();
    feed();
    waitDone(1'b1);
    syncs();
    pin(STX_CHAR, 0, 1, 1);
    repeat (4) pin(rndChar(), 0, 1, 1);
    pin(ETX_CHAR, 1, 1, 1);
    pbcc();
    expQ.push_back(PAD_CHAR);
    feed();
    waitDone(1'b0);
    cmpWire(0);
    // intermediate terminator as plain data
    noBlockCheck = 1'b1;
    msgStart();
    pin(STX_CHAR, 0, 1, 0);
    pin(rndChar(), 0, 1, 1);
    pin(ITB_CHAR, 0, 1, 1);
    pin(rndChar(), 0, 1, 1);
    pin(ETX_CHAR, 1, 1, 1);
    pbcc();
    expQ.push_back(PAD_CHAR);
    feed();
    waitDone(1'b0);
    cmpWire(0);
    noBlockCheck = 1'b0;
    // single-character endings outside text
    for (int j = 0; j < 3; j++) begin
      msgStart();
      pin(j == 0 ? EOT_CHAR : j == 1 ? ENQ_CHAR : NAK_CHAR, 1, 1, 0);
      expQ.push_back(PAD_CHAR);
      feed();
      waitDone(1'b0);
      cmpWire(0);
    end
    // transparent text: doubled escape, early terminator byte is data
    for (int t = 0; t < 2; t++) begin
      msgStart();
      pin(DLE_CHAR, 0, 1, 0);
      pin(STX_CHAR, 0, 1, 0);
      pin(rndChar(), 0, 1, 1);
      pin(DLE_CHAR, 0, 1, 1);
      expQ.push_back(DLE_CHAR);
      pin(ETX_CHAR, 0, 1, 1);
      expQ.push_back(DLE_CHAR);
      pin(t == 0 ? ETX_CHAR : ENQ_CHAR, 1, 1, 1);
      if (t == 0) pbcc();
      expQ.push_back(PAD_CHAR);
      feed();
      waitDone(1'b0);
      cmpWire(1);
    end
    // test mode: stored bytes go out with odd parity only; starvation reports underflow
    testMode = 1'b1;
    parityEnable = 1'b1;
    msgStart();
    for (int j = 0; j < 4; j++) begin
      ev = (j == 1) ? DLE_CHAR : (j == 2) ? ETX_CHAR : rndChar();
      pin(ev, j == 3, 0, 0);
      expQ.push_back({~(^ev[6:0]), ev[6:0]});
    end
    readSelect = SEL_STATUS;
    feed();
    waitDone(1'b1);
    chk1("underflow bit", 1'b1, readData[ST_UNDERFLOW]);
    cmpWire(0);
    txStop = 1'b1;
    @(negedge sys_clk);
    txStop = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk1("transmitBit", 1'b0, transmitBit);
    testMode = 1'b0;
    parityEnable = 1'b0;
    summarize();
  end
endmodule // tb_top
